// file: dv/msl_link_supervisor_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checks for the link supervisor
// ------------------------------------------------------------
module msl_link_supervisor_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        mb_frame_end,
    input wire logic        mb_frame_wr,
    input wire logic        mb_addr_hit,
    input wire logic        mb_wr_refused,
    input wire logic        alarm_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bus answer: one wait state, one-cycle strobe, data only with it
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // line side: pulses tied to the frame one cycle earlier
    a_hit_cause: assert property (mb_addr_hit |-> $past(mb_frame_end))
        else $error("hit without frame");
    a_refuse_cause: assert property (mb_wr_refused |-> mb_addr_hit && $past(mb_frame_wr))
        else $error("refusal without matched write");
    // alarm is sticky until traffic resumes or a bus write moves the setting
    a_alarm_clear: assert property (mb_frame_end |=> !alarm_active)
        else $error("alarm kept after frame");
    a_alarm_hold: assert property (alarm_active && !mb_frame_end && !$past(pready)
        |=> alarm_active)
        else $error("alarm dropped without frame");
endmodule

bind msl_link_supervisor msl_link_supervisor_checker i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mb_frame_end(mb_frame_end), .mb_frame_wr(mb_frame_wr), .mb_addr_hit(mb_addr_hit),
    .mb_wr_refused(mb_wr_refused), .alarm_active(alarm_active));
`default_nettype wire

// file: dv/msl_link_supervisor_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module msl_link_supervisor_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mb_addr_hit, mb_wr_refused;
    logic reply_start, alarm_active, irq, fe, fw, hit, rf, er;
    logic [7:0] paddr, fa, fi;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] fd, ao_value;
    logic [2:0] line_rate_sel;
    logic [1:0] relay_out;
    int fail_count = 0;
    int n_compared = 0;
    int n, e;
    msl_mb_master i_mst (.pclk(pclk), .mb_frame_end(fe), .mb_frame_addr(fa), .mb_frame_wr(fw),
        .mb_wr_index(fi), .mb_wr_data(fd));
    // short second and char time keep the run brief: char = 11 cycles at rate 7
    msl_link_supervisor #(.CLK_HZ(115200), .SEC_CYC(100)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .mb_frame_end(fe),
        .mb_frame_addr(fa), .mb_frame_wr(fw), .mb_wr_index(fi), .mb_wr_data(fd),
        .mb_addr_hit(mb_addr_hit), .mb_wr_refused(mb_wr_refused), .reply_start(reply_start),
        .line_rate_sel(line_rate_sel), .relay_out(relay_out), .ao_value(ao_value),
        .alarm_active(alarm_active), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // bus and frame tasks
    // ------------------------------------------------------------
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        // answer taken at the rising edge that sees pready, then released
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) fail_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task frame(input logic [7:0] a, input logic w, input logic [7:0] i, input logic [15:0] d);
        i_mst.send(a, w, i, d);
        #1;
        hit = mb_addr_hit;
        rf = mb_wr_refused;
    endtask
    task tick(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask
    task final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #(20 * 30000);
        fail_count++;
        final_report();
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        `CHK(line_rate_sel, msl_pkg::MSL_RATE_RST)
        apb(1'b0, msl_pkg::MSL_OFS_STATION, 32'h0);
        `CHK(rd[7:0], msl_pkg::MSL_STATION_RST)
        apb(1'b1, msl_pkg::MSL_OFS_STATION, 32'hc7);
        `CHK(er, 1'b0)
        frame(8'hc7, 1'b0, 8'h00, 16'h0000);
        `CHK(hit, 1'b1)
        frame(8'hc6, 1'b0, 8'h00, 16'h0000);
        `CHK(hit, 1'b0)
        apb(1'b1, msl_pkg::MSL_OFS_STATION, 32'hc8);
        `CHK(er, 1'b1)
        apb(1'b1, msl_pkg::MSL_OFS_STATION, 32'h0);
        frame(8'hff, 1'b0, 8'h00, 16'h0000);
        `CHK(hit, 1'b1)
        frame(8'h00, 1'b0, 8'h00, 16'h0000);
        `CHK(hit, 1'b0)
        $display("test station done");
        for (int r = 0; r < 8; r++) begin
            apb(1'b1, msl_pkg::MSL_OFS_RATE, r);
            tick(1);
            `CHK(line_rate_sel, r[2:0])
        end
        $display("test rate done");
        frame(8'hff, 1'b1, msl_pkg::MSL_IDX_RATE, 16'h0002);
        `CHK(rf, 1'b1)
        tick(1);
        `CHK(line_rate_sel, 3'h7)
        frame(8'hff, 1'b1, msl_pkg::MSL_IDX_AO_CMD, 16'h0005);
        `CHK(rf, 1'b0)
        tick(1);
        `CHK(ao_value, 16'h0005)
        frame(8'hff, 1'b1, msl_pkg::MSL_IDX_RLY_CMD, 16'h0003);
        tick(1);
        `CHK(relay_out, 2'h3)
        apb(1'b1, msl_pkg::MSL_OFS_PERMIT, 32'h1);
        frame(8'hff, 1'b1, msl_pkg::MSL_IDX_RATE, 16'h0004);
        tick(1);
        `CHK(line_rate_sel, 3'h4)
        $display("test permit done");
        apb(1'b1, msl_pkg::MSL_OFS_GAP, 32'h64);
        `CHK(er, 1'b1)
        apb(1'b1, msl_pkg::MSL_OFS_RLY_AL, 32'h2);
        apb(1'b1, msl_pkg::MSL_OFS_AO_AL, 32'haa);
        apb(1'b1, msl_pkg::MSL_OFS_GAP, 32'h2);
        frame(8'hff, 1'b0, 8'h00, 16'h0000);
        tick(195);
        `CHK(alarm_active, 1'b0)
        tick(115);
        `CHK(alarm_active, 1'b1)
        `CHK(ao_value, 16'h00aa)
        `CHK(relay_out, 2'h2)
        frame(8'hff, 1'b0, 8'h00, 16'h0000);
        tick(1);
        `CHK(ao_value, 16'h0005)
        apb(1'b1, msl_pkg::MSL_OFS_GAP, 32'h0);
        tick(400);
        `CHK(alarm_active, 1'b0)
        $display("test gap done");
        apb(1'b1, msl_pkg::MSL_OFS_RATE, 32'h7);
        apb(1'b1, msl_pkg::MSL_OFS_REPLY, 32'h0);
        frame(8'hff, 1'b0, 8'h00, 16'h0000);
        `CHK(reply_start, 1'b1)
        for (int s = 1; s < 6; s++) begin
            apb(1'b1, msl_pkg::MSL_OFS_REPLY, s);
            frame(8'hff, 1'b0, 8'h00, 16'h0000);
            e = msl_pkg::MSL_REPLY_CHARS[s] * msl_pkg::MSL_CHAR_BITS;
            n = 0;
            while (reply_start !== 1'b1 && n < 3000) begin
                tick(1);
                n++;
            end
            `CHK((n >= e - 12) && (n <= e + 12), 1'b1)
        end
        $display("test reply done");
        apb(1'b1, msl_pkg::MSL_OFS_STATUS, 32'h7);
        apb(1'b1, msl_pkg::MSL_OFS_MASK, 32'h4);
        `CHK(irq, 1'b0)
        frame(8'hff, 1'b0, 8'h00, 16'h0000);
        tick(2);
        `CHK(irq, 1'b1)
        apb(1'b1, msl_pkg::MSL_OFS_STATUS, 32'h4);
        tick(2);
        `CHK(irq, 1'b0)
        $display("test irq done");
        final_report();
    end
endmodule
`default_nettype wire

// file: dv/msl_mb_master.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// line master: hands over one decoded frame per call
// ------------------------------------------------------------
module msl_mb_master (
    input  wire logic  pclk,
    output logic       mb_frame_end,
    output logic [7:0] mb_frame_addr,
    output logic       mb_frame_wr,
    output logic [7:0] mb_wr_index,
    output logic [15:0] mb_wr_data
);
    initial begin
        mb_frame_end = 1'b0;
        mb_frame_addr = 8'h00;
        mb_frame_wr = 1'b0;
        mb_wr_index = 8'h00;
        mb_wr_data = 16'h0000;
    end
    // fields go inverse after the strobe so a stale copy never passes
    task send(input logic [7:0] a, input logic w, input logic [7:0] i, input logic [15:0] d);
        @(posedge pclk);
        mb_frame_end <= 1'b1;
        mb_frame_addr <= a;
        mb_frame_wr <= w;
        mb_wr_index <= i;
        mb_wr_data <= d;
        @(posedge pclk);
        mb_frame_end <= 1'b0;
        mb_frame_addr <= ~a;
        mb_frame_wr <= ~w;
        mb_wr_index <= ~i;
        mb_wr_data <= ~d;
    endtask
endmodule
`default_nettype wire

// file: rtl/msl_char_timer.sv
`timescale 1ns/1ps
`default_nettype none
// one pulse per character time at the selected line rate
module msl_char_timer #(
    parameter int unsigned CLK_HZ = msl_pkg::MSL_CLK_HZ,
    parameter int          CW     = 20
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          restart,
    input  wire logic [2:0]    rate_sel,
    output logic               char_tick
);
    logic [CW-1:0] cnt_reg;

    // constant divisor per rate, no run-time divider
    function automatic logic [CW-1:0] char_cycles(input logic [2:0] s);
        logic [CW-1:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            if (s == 3'(i)) begin
                r = CW'(CLK_HZ * msl_pkg::MSL_CHAR_BITS
                        / msl_pkg::MSL_RATE_BPS[i] - 1);
            end
        end
        return r;
    endfunction

    // restart aligns the first tick to a whole character after the frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg   <= '0;
            char_tick <= 1'b0;
        end else if (restart) begin
            cnt_reg   <= char_cycles(rate_sel);
            char_tick <= 1'b0;
        end else if (cnt_reg == '0) begin
            cnt_reg   <= char_cycles(rate_sel);
            char_tick <= 1'b1;
        end else begin
            cnt_reg   <= cnt_reg - 1'b1;
            char_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: rtl/msl_link_supervisor.sv
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module msl_link_supervisor #(
    parameter int unsigned CLK_HZ   = msl_pkg::MSL_CLK_HZ,
    parameter int unsigned SEC_CYC  = msl_pkg::MSL_SEC_TIME_S * CLK_HZ,
    parameter int          N_RELAY  = 2,
    parameter int          AO_W     = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              mb_frame_end,
    input  wire logic [7:0]        mb_frame_addr,
    input  wire logic              mb_frame_wr,
    input  wire logic [7:0]        mb_wr_index,
    input  wire logic [15:0]       mb_wr_data,
    output logic                   mb_addr_hit,
    output logic                   mb_wr_refused,
    output logic                   reply_start,
    output logic [2:0]             line_rate_sel,
    output logic [N_RELAY-1:0]     relay_out,
    output logic [AO_W-1:0]        ao_value,
    output logic                   alarm_active,
    output logic                   irq
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef enum logic [0:0] {
        MSL_RP_IDLE = 1'b0,
        MSL_RP_WAIT = 1'b1
    } msl_reply_t;

    logic [7:0]          station_reg;
    logic [2:0]          rate_reg;
    logic                remote_config_write_permit_reg;
    logic [6:0]          frame_gap_timeout_reg;
    logic [2:0]          reply_delay_setting_reg;
    logic [N_RELAY-1:0]  relay_alarm_reg;
    logic [AO_W-1:0]     ao_alarm_reg;
    logic                ao_hold_reg;
    logic [AO_W-1:0]     ao_cmd_reg;
    logic [N_RELAY-1:0]  relay_cmd_reg;
    logic [msl_pkg::MSL_ST_W-1:0] status_reg;
    logic [msl_pkg::MSL_ST_W-1:0] mask_reg;
    logic [31:0]         sec_div_reg;
    logic [6:0]          gap_sec_reg;
    logic [7:0]          reply_cnt_reg;
    msl_reply_t          reply_reg;
    logic                char_tick;
    logic                alarm_next;

    // -------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------
    // address match used by both hit pulse and write acceptance
    function automatic logic addr_match(input logic [7:0] id,
                                        input logic [7:0] a);
        if (id == 8'h00) begin
            return a == msl_pkg::MSL_ADDR_ZERO;
        end
        return a == id;
    endfunction

    function automatic logic [7:0] reply_chars(input logic [2:0] s);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            if (s == 3'(i)) begin
                r = 8'(msl_pkg::MSL_REPLY_CHARS[i]);
            end
        end
        return r;
    endfunction

    logic apb_setup;
    logic apb_wr;
    logic hit;
    logic mb_wr;
    logic mb_always;
    logic mb_cfg;
    logic mb_bad_val;
    logic mb_accept;

    // access phase completes on the cycle pready is already high
    assign apb_setup = psel && penable && !pready;
    assign apb_wr    = psel && penable && pready && pwrite && !pslverr;
    assign hit       = mb_frame_end && addr_match(station_reg, mb_frame_addr);
    assign mb_wr     = hit && mb_frame_wr;
    assign mb_always = (mb_wr_index == msl_pkg::MSL_IDX_AO_CMD)
                    || (mb_wr_index == msl_pkg::MSL_IDX_RLY_CMD);
    assign mb_cfg    = (mb_wr_index == msl_pkg::MSL_IDX_GAP)
                    || (mb_wr_index == msl_pkg::MSL_IDX_REPLY)
                    || (mb_wr_index == msl_pkg::MSL_IDX_RATE)
                    || (mb_wr_index == msl_pkg::MSL_IDX_STATION);
    // out-of-range station and gap values are refused instead of clipped
    assign mb_bad_val =
        ((mb_wr_index == msl_pkg::MSL_IDX_STATION)
            && (mb_wr_data > 16'(msl_pkg::MSL_STATION_MAX)))
     || ((mb_wr_index == msl_pkg::MSL_IDX_GAP)
            && (mb_wr_data > 16'(msl_pkg::MSL_GAP_MAX)));
    assign mb_accept = mb_wr && (mb_always
                    || (mb_cfg && remote_config_write_permit_reg
                        && !mb_bad_val));

    // -------------------------------------------------------------
    // apb slave: one wait state so every answer leaves a flop
    // -------------------------------------------------------------
    function automatic logic apb_bad(input logic [7:0] a,
                                     input logic       w,
                                     input logic [31:0] d);
        logic b;
        b = 1'b0;
        unique case (a)
            msl_pkg::MSL_OFS_STATION: b = w && (d[7:0] > msl_pkg::MSL_STATION_MAX);
            msl_pkg::MSL_OFS_GAP:     b = w && (d[6:0] > msl_pkg::MSL_GAP_MAX);
            msl_pkg::MSL_OFS_STATE:   b = w;
            msl_pkg::MSL_OFS_RATE, msl_pkg::MSL_OFS_PERMIT,
            msl_pkg::MSL_OFS_REPLY, msl_pkg::MSL_OFS_RLY_AL,
            msl_pkg::MSL_OFS_AO_AL, msl_pkg::MSL_OFS_STATUS,
            msl_pkg::MSL_OFS_MASK:    b = 1'b0;
            default:                  b = 1'b1;
        endcase
        return b;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup && apb_bad(paddr, pwrite, pwdata);
            if (apb_setup && !pwrite) begin
                unique case (paddr)
                    msl_pkg::MSL_OFS_STATION: prdata <= 32'(station_reg);
                    msl_pkg::MSL_OFS_RATE:    prdata <= 32'(rate_reg);
                    msl_pkg::MSL_OFS_PERMIT:
                        prdata <= 32'(remote_config_write_permit_reg);
                    msl_pkg::MSL_OFS_GAP:     prdata <= 32'(frame_gap_timeout_reg);
                    msl_pkg::MSL_OFS_REPLY:   prdata <= 32'(reply_delay_setting_reg);
                    msl_pkg::MSL_OFS_RLY_AL:  prdata <= 32'(relay_alarm_reg);
                    msl_pkg::MSL_OFS_AO_AL:
                        prdata <= 32'({ao_hold_reg, ao_alarm_reg});
                    msl_pkg::MSL_OFS_STATUS:  prdata <= 32'(status_reg);
                    msl_pkg::MSL_OFS_MASK:    prdata <= 32'(mask_reg);
                    msl_pkg::MSL_OFS_STATE:
                        prdata <= 32'({reply_reg, alarm_active});
                    default:                  prdata <= '0;
                endcase
            end else begin
                prdata <= '0;
            end
        end
    end

    // -------------------------------------------------------------
    // configuration: local bus first, then accepted line writes
    // -------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            station_reg                    <= msl_pkg::MSL_STATION_RST;
            rate_reg                       <= msl_pkg::MSL_RATE_RST;
            remote_config_write_permit_reg <= 1'b0;
            frame_gap_timeout_reg          <= msl_pkg::MSL_GAP_RST;
            reply_delay_setting_reg        <= msl_pkg::MSL_REPLY_RST;
            relay_alarm_reg                <= '0;
            ao_alarm_reg                   <= '0;
            ao_hold_reg                    <= 1'b0;
            mask_reg                       <= '0;
        end else if (apb_wr) begin
            unique case (paddr)
                msl_pkg::MSL_OFS_STATION: station_reg <= pwdata[7:0];
                msl_pkg::MSL_OFS_RATE:    rate_reg <= pwdata[2:0];
                msl_pkg::MSL_OFS_PERMIT:
                    remote_config_write_permit_reg <= pwdata[0];
                msl_pkg::MSL_OFS_GAP:     frame_gap_timeout_reg <= pwdata[6:0];
                msl_pkg::MSL_OFS_REPLY:   reply_delay_setting_reg <= pwdata[2:0];
                msl_pkg::MSL_OFS_RLY_AL:  relay_alarm_reg <= pwdata[N_RELAY-1:0];
                msl_pkg::MSL_OFS_AO_AL: begin
                    ao_alarm_reg <= pwdata[AO_W-1:0];
                    ao_hold_reg  <= pwdata[msl_pkg::MSL_AO_HOLD_BIT];
                end
                msl_pkg::MSL_OFS_MASK:    mask_reg <= pwdata[msl_pkg::MSL_ST_W-1:0];
                default: ;
            endcase
        end else if (mb_accept) begin
            unique case (mb_wr_index)
                msl_pkg::MSL_IDX_GAP:     frame_gap_timeout_reg <= mb_wr_data[6:0];
                msl_pkg::MSL_IDX_REPLY:   reply_delay_setting_reg <= mb_wr_data[2:0];
                msl_pkg::MSL_IDX_RATE:    rate_reg <= mb_wr_data[2:0];
                msl_pkg::MSL_IDX_STATION: station_reg <= mb_wr_data[7:0];
                default: ;
            endcase
        end
    end

    // line-controlled set points, never gated by the permit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ao_cmd_reg    <= '0;
            relay_cmd_reg <= '0;
        end else if (mb_accept) begin
            if (mb_wr_index == msl_pkg::MSL_IDX_AO_CMD) begin
                ao_cmd_reg <= mb_wr_data[AO_W-1:0];
            end
            if (mb_wr_index == msl_pkg::MSL_IDX_RLY_CMD) begin
                relay_cmd_reg <= mb_wr_data[N_RELAY-1:0];
            end
        end
    end

    // -------------------------------------------------------------
    // frame-gap supervision
    // -------------------------------------------------------------
    // any complete frame restarts the gap, whoever it was addressed to
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_div_reg <= '0;
            gap_sec_reg <= '0;
        end else if (mb_frame_end) begin
            sec_div_reg <= '0;
            gap_sec_reg <= '0;
        end else if (sec_div_reg == SEC_CYC - 1) begin
            sec_div_reg <= '0;
            if (gap_sec_reg != 7'h7f) begin
                gap_sec_reg <= gap_sec_reg + 7'h01;
            end
        end else begin
            sec_div_reg <= sec_div_reg + 32'h1;
        end
    end

    // alarm only once the gap strictly exceeds the setting
    assign alarm_next = (frame_gap_timeout_reg != 7'h00)
                     && (gap_sec_reg > frame_gap_timeout_reg)
                     && !mb_frame_end;

    // outputs: alarm values while timed out (ao_value held instead when ao_hold_reg is set), normal values after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_active <= 1'b0;
            relay_out    <= '0;
            ao_value     <= '0;
        end else begin
            alarm_active <= alarm_next;
            if (alarm_next) begin
                relay_out <= relay_alarm_reg;
                if (!ao_hold_reg) begin
                    ao_value <= ao_alarm_reg;
                end
            end else begin
                relay_out <= relay_cmd_reg;
                ao_value  <= ao_cmd_reg;
            end
        end
    end

    // -------------------------------------------------------------
    // reply timing
    // -------------------------------------------------------------
    msl_char_timer #(
        .CLK_HZ (CLK_HZ)
    ) u_char (
        .pclk      (pclk),
        .presetn   (presetn),
        .restart   (hit),
        .rate_sel  (rate_reg),
        .char_tick (char_tick)
    );

    // a new matching frame restarts any pending wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reply_reg     <= MSL_RP_IDLE;
            reply_cnt_reg <= '0;
            reply_start   <= 1'b0;
        end else if (hit) begin
            if (reply_chars(reply_delay_setting_reg) == 8'h00) begin
                reply_reg   <= MSL_RP_IDLE;
                reply_start <= 1'b1;
            end else begin
                reply_reg     <= MSL_RP_WAIT;
                reply_cnt_reg <= reply_chars(reply_delay_setting_reg);
                reply_start   <= 1'b0;
            end
        end else begin
            reply_start <= 1'b0;
            unique case (reply_reg)
                MSL_RP_IDLE: ;
                MSL_RP_WAIT: begin
                    if (char_tick) begin
                        reply_cnt_reg <= reply_cnt_reg - 8'h01;
                        if (reply_cnt_reg == 8'h01) begin
                            reply_reg   <= MSL_RP_IDLE;
                            reply_start <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // line-side pulses, status and interrupt
    // -------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mb_addr_hit   <= 1'b0;
            mb_wr_refused <= 1'b0;
            line_rate_sel <= msl_pkg::MSL_RATE_RST;
        end else begin
            mb_addr_hit   <= hit;
            mb_wr_refused <= mb_wr && !mb_accept;
            line_rate_sel <= rate_reg;
        end
    end

    logic [msl_pkg::MSL_ST_W-1:0] st_set;
    logic [msl_pkg::MSL_ST_W-1:0] st_clr;

    assign st_set[msl_pkg::MSL_ST_ALARM]   = alarm_next && !alarm_active;
    assign st_set[msl_pkg::MSL_ST_REFUSED] = mb_wr && !mb_accept;
    assign st_set[msl_pkg::MSL_ST_HIT]     = hit;
    assign st_clr = (apb_wr && paddr == msl_pkg::MSL_OFS_STATUS)
                  ? pwdata[msl_pkg::MSL_ST_W-1:0] : '0;

    // write-one-to-clear; a fresh event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= '0;
            irq        <= 1'b0;
        end else begin
            status_reg <= (status_reg & ~st_clr) | st_set;
            irq        <= |(((status_reg & ~st_clr) | st_set) & mask_reg);
        end
    end
endmodule
`default_nettype wire

// file: rtl/msl_pkg.sv
package msl_pkg;
    // -------------------------------------------------------------
    // apb register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] MSL_OFS_STATION = 8'h00;
    localparam logic [7:0] MSL_OFS_RATE    = 8'h04;
    localparam logic [7:0] MSL_OFS_PERMIT  = 8'h08;
    localparam logic [7:0] MSL_OFS_GAP     = 8'h0c;
    localparam logic [7:0] MSL_OFS_REPLY   = 8'h10;
    localparam logic [7:0] MSL_OFS_RLY_AL  = 8'h14;
    localparam logic [7:0] MSL_OFS_AO_AL   = 8'h18;
    localparam logic [7:0] MSL_OFS_STATUS  = 8'h1c;
    localparam logic [7:0] MSL_OFS_MASK    = 8'h20;
    localparam logic [7:0] MSL_OFS_STATE   = 8'h24;

    // -------------------------------------------------------------
    // line-side register indices
    // -------------------------------------------------------------
    localparam logic [7:0] MSL_IDX_AO_CMD  = 8'h04;
    localparam logic [7:0] MSL_IDX_RLY_CMD = 8'h05;
    localparam logic [7:0] MSL_IDX_GAP     = 8'h10;
    localparam logic [7:0] MSL_IDX_REPLY   = 8'h11;
    localparam logic [7:0] MSL_IDX_RATE    = 8'h12;
    localparam logic [7:0] MSL_IDX_STATION = 8'h13;

    // -------------------------------------------------------------
    // limits, reset values, field positions
    // -------------------------------------------------------------
    localparam logic [7:0] MSL_STATION_MAX = 8'hc7;
    localparam logic [7:0] MSL_ADDR_ZERO   = 8'hff;
    localparam logic [6:0] MSL_GAP_MAX     = 7'h63;
    localparam logic [7:0] MSL_STATION_RST = 8'h01;
    localparam logic [2:0] MSL_RATE_RST    = 3'h3;
    localparam logic [2:0] MSL_REPLY_RST   = 3'h0;
    localparam logic [6:0] MSL_GAP_RST     = 7'h00;
    localparam int         MSL_ST_ALARM    = 0;
    localparam int         MSL_ST_REFUSED  = 1;
    localparam int         MSL_ST_HIT      = 2;
    localparam int         MSL_ST_W        = 3;
    localparam int         MSL_AO_HOLD_BIT = 16;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int unsigned MSL_CLK_HZ     = 50_000_000;
    localparam int unsigned MSL_SEC_TIME_S = 1;
    localparam int unsigned MSL_CHAR_BITS  = 11;
    localparam int unsigned MSL_RATE_BPS [8] = '{
        1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
    localparam int unsigned MSL_REPLY_CHARS [8] = '{
        0, 10, 20, 50, 100, 200, 0, 0};
endpackage
